// ### fps_top.sv
// module: field-pair decode, near-field safety outputs with pulse test and restart gating
// How it works
// R1 - up to eight field pairs are chosen from the four select inputs; the code reaches only pairs one to four and pair eight.
// R2 - a select input counts as one only while driven high; the outside asserts inputs to pick pairs.
// R3 - with no select input asserted, pair one is active.
// R4 - an illegal combination drives the warning output low, drops both near outputs and pulses error reports.
// R5 - two pairs may be active at once so the outside can switch make-before-break.
// R6 - each near output is high while the near field is clear and low while an object is in it.
// R7 - every 20 ms one near output drops for 100 us, the two outputs taking turns.
// R8 - the outside load must filter the test dropouts below 1 kHz.
// R9 - a restart re-enables the outputs and the green lamp only if the near field is then clear.
// R10 - the serial port uses RS 422 when the strap is grounded and RS 232 when it floats.
// R11 - a restart press counts only if held between 0.12 s and 3 s.
// R12 - the warning output goes low whenever a device warning or error is present.
// R13 - select inputs are synchronised and debounced before decoding.
module fps_top #(
    parameter int unsigned TEST_PERIOD_CYC = fps_pkg::TEST_PERIOD_CYC,
    parameter int unsigned TEST_GAP_CYC    = fps_pkg::TEST_GAP_CYC,
    parameter int unsigned RESTART_MIN_CYC = fps_pkg::RESTART_MIN_CYC,
    parameter int unsigned RESTART_MAX_CYC = fps_pkg::RESTART_MAX_CYC,
    parameter int unsigned DEBOUNCE_CYC    = fps_pkg::DEBOUNCE_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] pair_select_i,
    input  wire logic       near_object_i,
    input  wire logic       restart_i,
    input  wire logic       device_fault_i,
    input  wire logic       iface_strap_n_i,
    output logic [7:0]      active_pairs_o,
    output logic            near_safe_out_a_o,
    output logic            near_safe_out_b_o,
    output logic            warn_error_out_o,
    output logic            green_led_o,
    output logic            select_error_o,
    output logic            use_rs422_o
);
    localparam int CW = 32;

    // one-hot pair decode; bits 0..7 pick pairs, bit 8 flags an illegal code (legal: none, one input, two adjacent inputs, or inputs 0 and 3)
    function automatic logic [8:0] decode_sel(input logic [3:0] s);
        logic [8:0] r;
        r = 9'h000;
        case (s)
            4'h0:    r = {1'b0, fps_pkg::PAIR_DEFAULT};
            4'h1:    r = 9'h001;
            4'h2:    r = 9'h002;
            4'h4:    r = 9'h004;
            4'h8:    r = 9'h008;
            4'h3:    r = 9'h010;
            4'h6:    r = 9'h020;
            4'hc:    r = 9'h040;
            4'h9:    r = 9'h080;
            default: r = 9'h100;
        endcase
        return r;
    endfunction : decode_sel

    // select path: two-stage sync then stability counter
    logic [3:0]    sync1;
    logic [3:0]    sync2;
    logic [3:0]    stable;
    logic [3:0]    next_stable;
    logic [CW-1:0] db_cnt;
    logic [CW-1:0] next_db_cnt;
    logic [3:0]    cand;
    logic [3:0]    next_cand;
    always_comb begin
        next_cand   = cand;
        next_db_cnt = db_cnt;
        next_stable = stable;
        if (sync2 != cand) begin
            next_cand   = sync2;
            next_db_cnt = '0;
        end else if (db_cnt >= DEBOUNCE_CYC - 1) begin
            next_stable = cand; // [R13] [R2]
        end else begin
            next_db_cnt = db_cnt + 1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1  <= 4'h0;
            sync2  <= 4'h0;
            cand   <= 4'h0;
            stable <= 4'h0;
            db_cnt <= '0;
        end else begin
            sync1  <= pair_select_i;
            sync2  <= sync1;
            cand   <= next_cand;
            stable <= next_stable;
            db_cnt <= next_db_cnt;
        end
    end

    // pair decode; an adjacent two-input code means both pairs active during changeover
    logic [8:0] dec;
    logic [7:0] next_pairs;
    logic       sel_bad;
    always_comb begin
        dec        = decode_sel(stable); // [R1] [R3]
        sel_bad    = dec[8] || (stable == fps_pkg::SEL_ALL_ON); // [R4]
        next_pairs = 8'h00;
        case (stable)
            4'h3:    next_pairs = 8'h03; // [R5]
            4'h6:    next_pairs = 8'h06; // [R5]
            4'hc:    next_pairs = 8'h0c; // [R5]
            default: next_pairs = sel_bad ? 8'h00 : dec[7:0];
        endcase
    end

    // pulse-test timer: channel a or b drops for the gap at the start of each period
    logic [CW-1:0] tp_cnt;
    logic [CW-1:0] next_tp_cnt;
    logic          turn_b;
    logic          next_turn_b;
    logic          gap;
    always_comb begin
        next_turn_b = turn_b;
        if (tp_cnt >= TEST_PERIOD_CYC - 1) begin
            next_tp_cnt = '0;
            next_turn_b = ~turn_b; // [R7]
        end else begin
            next_tp_cnt = tp_cnt + 1;
        end
        // the dropout is kept short so a slow load filter rides through it
        gap = (tp_cnt < TEST_GAP_CYC); // [R7] [R8]
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tp_cnt <= '0;
            turn_b <= 1'b0;
        end else begin
            tp_cnt <= next_tp_cnt;
            turn_b <= next_turn_b;
        end
    end

    // restart lock: a violation trips; a valid-length press on a clear field re-arms
    fps_pkg::fps_state_t state;
    fps_pkg::fps_state_t next_state;
    logic [CW-1:0]       rs_cnt;
    logic [CW-1:0]       next_rs_cnt;
    logic                rs_d;
    logic                press_ok;
    always_comb begin
        next_state  = state;
        next_rs_cnt = rs_cnt;
        press_ok    = 1'b0;
        if (restart_i) begin
            if (rs_cnt != RESTART_MAX_CYC) begin
                next_rs_cnt = rs_cnt + 1;
            end
        end else begin
            next_rs_cnt = '0;
            // falling edge of a press held within the window
            press_ok = rs_d && (rs_cnt >= RESTART_MIN_CYC) && (rs_cnt <= RESTART_MAX_CYC - 1); // [R11]
        end
        case (state)
            fps_pkg::FPS_ARMED: begin
                if (near_object_i || sel_bad) begin
                    next_state = fps_pkg::FPS_TRIPPED;
                end
            end
            fps_pkg::FPS_TRIPPED: begin
                if (restart_i) begin
                    next_state = fps_pkg::FPS_HOLD;
                end
            end
            fps_pkg::FPS_HOLD: begin
                if (!restart_i) begin
                    // a press on an occupied field leaves the outputs off
                    next_state = (press_ok && !near_object_i && !sel_bad) ? fps_pkg::FPS_ARMED
                                                                          : fps_pkg::FPS_TRIPPED; // [R9]
                end
            end
            default: next_state = fps_pkg::FPS_TRIPPED;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state  <= fps_pkg::FPS_TRIPPED; // start disable after system start
            rs_cnt <= '0;
            rs_d   <= 1'b0;
        end else begin
            state  <= next_state;
            rs_cnt <= next_rs_cnt;
            rs_d   <= restart_i;
        end
    end

    // output stage, every port registered
    fps_pkg::fps_out_t outs;
    fps_pkg::fps_out_t next_outs;
    logic              bad_d;
    logic              next_err;
    always_comb begin
        // outputs are cut at the clock edge after the fault is seen, not a cycle later via the state
        logic run;
        run = (state == fps_pkg::FPS_ARMED) && !near_object_i && !sel_bad; // [R6] [R4]
        next_outs.near_safe_out_a = run && !(gap && !turn_b); // [R7] [R6]
        next_outs.near_safe_out_b = run && !(gap && turn_b);  // [R7] [R6]
        next_outs.green_led       = run; // [R9]
        next_outs.warn_error_out  = !(sel_bad || device_fault_i); // [R12] [R4]
        next_err                  = sel_bad && !bad_d; // [R4]
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            outs           <= '{warn_error_out: 1'b1, default: 1'b0};
            bad_d          <= 1'b0;
            select_error_o <= 1'b0;
            active_pairs_o <= 8'h00;
            use_rs422_o    <= 1'b0;
        end else begin
            outs           <= next_outs;
            bad_d          <= sel_bad;
            select_error_o <= next_err;
            active_pairs_o <= next_pairs;
            use_rs422_o    <= ~iface_strap_n_i; // [R10]
        end
    end
    assign near_safe_out_a_o = outs.near_safe_out_a;
    assign near_safe_out_b_o = outs.near_safe_out_b;
    assign warn_error_out_o  = outs.warn_error_out;
    assign green_led_o       = outs.green_led;
endmodule : fps_top

// ### fps_pkg.sv
// package: constants and carrier types for the field-pair select and safety output block
package fps_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TEST_PERIOD_MS  = 20;
    localparam int unsigned TEST_GAP_US     = 100;
    localparam int unsigned RESTART_MIN_MS  = 120;
    localparam int unsigned RESTART_MAX_MS  = 3000;
    localparam int unsigned TEST_PERIOD_CYC = (CLK_HZ / 1000) * TEST_PERIOD_MS;
    localparam int unsigned TEST_GAP_CYC    = (CLK_HZ / 1_000_000) * TEST_GAP_US;
    localparam int unsigned RESTART_MIN_CYC = (CLK_HZ / 1000) * RESTART_MIN_MS;
    localparam int unsigned RESTART_MAX_CYC = (CLK_HZ / 1000) * RESTART_MAX_MS;
    localparam int unsigned DEBOUNCE_CYC    = 16;
    localparam int unsigned NUM_PAIRS       = 8;
    localparam logic [3:0]  SEL_ALL_ON      = 4'hf;
    localparam logic [7:0]  PAIR_DEFAULT    = 8'h01;

    typedef struct packed {
        logic warn_error_out;
        logic near_safe_out_a;
        logic near_safe_out_b;
        logic green_led;
    } fps_out_t;

    typedef enum logic [1:0] {
        FPS_ARMED,
        FPS_TRIPPED,
        FPS_HOLD
    } fps_state_t;
endpackage : fps_pkg

// ### fps_partner.sv
// machine-side model: select switches, restart button and relays on the near outputs
module fps_partner (
    input  wire logic       clk_i,
    input  wire logic       near_safe_out_a_i,
    input  wire logic       near_safe_out_b_i,
    output logic [3:0]      pair_select_o,
    output logic            restart_o,
    output logic            relay_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned FILT_CYC = 20;
    int unsigned low_a = 0;
    int unsigned low_b = 0;
    initial pair_select_o = 4'h0;
    initial restart_o = 1'b0;
    // slow relay coil: dropouts shorter than FILT_CYC never open it
    always @(posedge clk_i) begin
        low_a <= near_safe_out_a_i ? 0 : low_a + 1;
        low_b <= near_safe_out_b_i ? 0 : low_b + 1;
    end
    assign relay_o = (low_a < FILT_CYC) && (low_b < FILT_CYC);
    // sets the whole code at once; old and new pair overlap only when a caller passes a two-input code
    task automatic select_pairs(input logic [3:0] code);
        @(posedge clk_i);
        #5 pair_select_o = code;
    endtask : select_pairs
    task automatic press(input int cycles);
        @(posedge clk_i);
        #5 restart_o = 1'b1;
        repeat (cycles) @(posedge clk_i);
        #5 restart_o = 1'b0;
    endtask : press
endmodule : fps_partner

// ### fps_top_sva.sv
// checker: port-level properties of the field-pair and safety output block
module fps_top_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       near_object_i,
    input wire logic       restart_i,
    input wire logic       device_fault_i,
    input wire logic       iface_strap_n_i,
    input wire logic [3:0] pair_select_i,
    input wire logic [7:0] active_pairs_o,
    input wire logic       near_safe_out_a_o,
    input wire logic       near_safe_out_b_o,
    input wire logic       warn_error_out_o,
    input wire logic       green_led_o,
    input wire logic       select_error_o,
    input wire logic       use_rs422_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_strap; !$past(rst_i) |-> use_rs422_o == $past(!iface_strap_n_i); endproperty
    a_strap: assert property (p_strap) else $error("strap not followed");
    property p_shape; $countones(active_pairs_o) <= 2; endproperty
    a_shape: assert property (p_shape) else $error("too many pairs");
    property p_illegal;
        select_error_o |-> (!warn_error_out_o && active_pairs_o == 8'h00 && !near_safe_out_a_o
            && !near_safe_out_b_o) ##1 !select_error_o;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal select reaction wrong");
    property p_object; near_object_i |=> !near_safe_out_a_o && !near_safe_out_b_o; endproperty
    a_object: assert property (p_object) else $error("near outputs high with object");
    property p_fault; device_fault_i |=> !warn_error_out_o; endproperty
    a_fault: assert property (p_fault) else $error("fault not flagged");
    property p_warn; !warn_error_out_o |-> $past(device_fault_i) || active_pairs_o == 8'h00; endproperty
    a_warn: assert property (p_warn) else $error("warning without cause");
    property p_green; $rose(green_led_o) |-> !$past(near_object_i); endproperty
    a_green: assert property (p_green) else $error("armed with object present");
    // a pair change needs the input 4 cycles back to equal the input 8 cycles back
    property p_debounce;
        $changed(active_pairs_o) |-> $past(pair_select_i, 4) == $past(pair_select_i, 8);
    endproperty
    a_debounce: assert property (p_debounce) else $error("pairs followed unsettled input");
    c_err: cover property (select_error_o);
    c_arm: cover property ($rose(green_led_o));
    c_gap: cover property (!near_safe_out_a_o && near_safe_out_b_o);
endmodule : fps_top_sva

// ### fps_top_tb_top.sv
// testbench: drives select and restart through the machine model, object, fault and strap directly, and checks its outputs
module fps_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, obj, fault, strap_n;
    logic [3:0] sel;
    logic [7:0] pairs;
    logic restart, relay, na, nb, warn, led, serr, rs422;
    int n_errors = 0, tests_run = 0, n_serr = 0, la, lb, lab;
    logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'h6, 4'hc, 4'h0};
    logic [7:0] exp_p [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80, 8'h06, 8'h0c, 8'h01};
    always #25 clk = ~clk;
    always @(posedge clk) n_serr <= n_serr + serr;
    fps_top #(.TEST_PERIOD_CYC(200), .TEST_GAP_CYC(10), .RESTART_MIN_CYC(20), .RESTART_MAX_CYC(100),
        .DEBOUNCE_CYC(4)) dut (.clk_i(clk), .rst_i(rst), .pair_select_i(sel), .near_object_i(obj),
        .restart_i(restart), .device_fault_i(fault), .iface_strap_n_i(strap_n), .active_pairs_o(pairs),
        .near_safe_out_a_o(na), .near_safe_out_b_o(nb), .warn_error_out_o(warn), .green_led_o(led),
        .select_error_o(serr), .use_rs422_o(rs422));
    fps_partner mach (.clk_i(clk), .near_safe_out_a_i(na), .near_safe_out_b_i(nb), .pair_select_o(sel),
        .restart_o(restart), .relay_o(relay));
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // covers sync plus debounce with margin
    task automatic settle();
        repeat (12) @(posedge clk);
        #5;
    endtask : settle
    task automatic arm();
        mach.press(30);
        settle();
        chk("armed", {6'h0, led, relay}, 8'h03);
    endtask : arm
    task automatic locked(string what);
        chk(what, {5'h0, na, nb, led}, 8'h00);
    endtask : locked
    initial begin
        #300000;
        n_errors++;
        summarize();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        obj = 1'b0;
        fault = 1'b0;
        strap_n = 1'b0;
        repeat (8) @(posedge clk);
        #5 rst = 1'b0;
        @(posedge clk);
        #5 chk("rs422", {7'h0, rs422}, 8'h01);
        strap_n = 1'b1;
        settle();
        chk("rs232", {7'h0, rs422}, 8'h00);
        chk("default", pairs, 8'h01);
        locked("start_lock");
        arm();
        foreach (codes[i]) begin
            mach.select_pairs(codes[i]);
            settle();
            chk("pairs", pairs, exp_p[i]);
        end
        mach.select_pairs(4'h3);
        settle();
        chk("changeover", {6'h0, warn, relay}, 8'h03);
        chk("changeover_pairs", pairs, 8'h03);
        mach.select_pairs(4'hf);
        settle();
        chk("illegal", {pairs[6:0], warn}, 8'h00);
        locked("illegal_off");
        chk("err_pulses", n_serr[7:0], 8'h01);
        mach.select_pairs(4'h1);
        settle();
        chk("recover", {pairs[6:0], warn}, 8'h03);
        mach.press(5);
        settle();
        locked("short_press");
        arm();
        obj = 1'b1;
        repeat (2) @(posedge clk);
        #5 locked("object");
        mach.press(30);
        settle();
        locked("object_restart");
        obj = 1'b0;
        mach.press(120);
        settle();
        locked("long_press");
        arm();
        la = 0;
        lb = 0;
        lab = 0;
        repeat (400) begin
            @(posedge clk);
            #5 la += !na;
            lb += !nb;
            lab += !na && !nb;
        end
        chk("gap_a", la[7:0], 8'h0a);
        chk("gap_b", lb[7:0], 8'h0a);
        chk("gap_both", {lab[6:0], relay}, 8'h01);
        fault = 1'b1;
        repeat (2) @(posedge clk);
        #5 chk("fault", {7'h0, warn}, 8'h00);
        fault = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #5 rst = 1'b0;
        settle();
        locked("reset_lock");
        chk("reset_warn", {pairs[6:0], warn}, 8'h03);
        summarize();
    end
endmodule : fps_top_tb_top
bind fps_top fps_top_sva sva_i (.clk_i(clk_i), .rst_i(rst_i), .near_object_i(near_object_i),
    .restart_i(restart_i), .device_fault_i(device_fault_i), .iface_strap_n_i(iface_strap_n_i),
    .pair_select_i(pair_select_i), .active_pairs_o(active_pairs_o), .near_safe_out_a_o(near_safe_out_a_o),
    .near_safe_out_b_o(near_safe_out_b_o), .warn_error_out_o(warn_error_out_o), .green_led_o(green_led_o),
    .select_error_o(select_error_o), .use_rs422_o(use_rs422_o));
